// ==== inc/div_consts.svh ====
// Constants for the signed and BCD division datapath.
// Assumes inclusion by every design file that needs codes or widths.
`ifndef DIV_CONSTS_SVH
`define DIV_CONSTS_SVH

// ****************************************************************
// Function codes (430, 431, 434, 435 decimal)
// ****************************************************************
`define FC_SIGNED_SINGLE 10'h1ae
`define FC_SIGNED_DOUBLE 10'h1af
`define FC_BCD_SINGLE 10'h1b2
`define FC_BCD_DOUBLE 10'h1b3

// ****************************************************************
// Widths, field positions and reset values
// ****************************************************************
`define WORD_W 16
`define DWORD_W 32
`define DIGIT_W 4
`define CODE_W 10
`define SIGN_SINGLE 15
`define SIGN_DOUBLE 31
`define FLAG_RST 1'b0
`define WORD_RST 16'h0000

`endif

// ==== inc/div_pkg.sv ====
// Types shared by the division datapath modules.
// Assumes the constants header is compiled alongside.
package div_pkg;

  // Controller sequencing states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PREP = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } div_state_type;

  // Decoded operation
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SIGNED_SINGLE = 3'h1,
    OP_SIGNED_DOUBLE = 3'h2,
    OP_BCD_SINGLE = 3'h3,
    OP_BCD_DOUBLE_DIVIDE = 3'h4
  } div_op_type;

endpackage : div_pkg

// ==== inc/div_if.sv ====
// Handshake between the division controller and its magnitude engine.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface div_if #(parameter int WIDTH = 32);
  logic start;                 // One-cycle launch pulse
  logic [WIDTH-1:0] dividend;  // Unsigned dividend
  logic [WIDTH-1:0] divisor;   // Unsigned divisor, never zero
  logic done;                  // One-cycle completion pulse
  logic [WIDTH-1:0] quotient;  // Held until next launch
  logic [WIDTH-1:0] remainder; // Held until next launch

  modport ctrl(output start, dividend, divisor,
               input done, quotient, remainder);
  modport engine(input start, dividend, divisor,
                 output done, quotient, remainder);
endinterface : div_if

`default_nettype wire

// ==== rtl/mag_divider.sv ====
// Iterative unsigned restoring divider, one quotient bit per clock.
// Assumes a nonzero divisor and start only while idle.
`timescale 1ns/1ps
`default_nettype none

module mag_divider
  import div_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  div_if.engine div_bus
);
  localparam int CW = $clog2(WIDTH) + 1;

  logic [WIDTH-1:0] rem_q, rem_d;   // Partial remainder
  logic [WIDTH-1:0] quo_q, quo_d;   // Dividend shifting into quotient
  logic [WIDTH-1:0] den_q, den_d;   // Divisor
  logic [CW-1:0] cnt_q, cnt_d;      // Steps taken
  logic busy_q, busy_d;             // Iterating
  logic done_q, done_d;             // Finish pulse
  logic [WIDTH:0] shifted;          // Remainder with next bit in
  logic [WIDTH:0] trial;            // Trial subtraction

  // ****************************************************************
  // Next state
  // ****************************************************************
  // One restoring step per cycle; a borrow keeps the shifted remainder
  always_comb begin
    rem_d = rem_q;
    quo_d = quo_q;
    den_d = den_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    shifted = {rem_q, quo_q[WIDTH-1]};
    trial = shifted - {1'b0, den_q};
    if (div_bus.start) begin
      // Load operands
      rem_d = '0;
      quo_d = div_bus.dividend;
      den_d = div_bus.divisor;
      cnt_d = '0;
      busy_d = 1'b1;
    end else if (busy_q) begin
      // Keep difference unless it borrowed
      rem_d = trial[WIDTH] ? shifted[WIDTH-1:0] : trial[WIDTH-1:0];
      quo_d = {quo_q[WIDTH-2:0], ~trial[WIDTH]};
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == CW'(WIDTH - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Register the step
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      den_q <= den_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign div_bus.done = done_q;
  assign div_bus.quotient = quo_q;
  assign div_bus.remainder = rem_q;

  // Completion follows launch by a fixed count
  property p_div_latency;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      div_bus.start |-> ##33 div_bus.done;
  endproperty
  a_div_latency: assert property (p_div_latency)
    else $error("divider finish not 33 cycles after start");

  // No finish pulse before the last step has been taken
  property p_div_quiet;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      busy_q && cnt_q != CW'(WIDTH - 1) |=> !div_bus.done;
  endproperty
  a_div_quiet: assert property (p_div_quiet)
    else $error("divider finished early");

endmodule : mag_divider

`default_nettype wire

// ==== rtl/bcd_codec.sv ====
// Combinational BCD checks and conversions to and from binary.
// Assumes binary values fit in the digit count given.
`timescale 1ns/1ps
`default_nettype none
`include "div_consts.svh"

module bcd_codec #(
  parameter int DIGITS = 8
) (
  input wire logic [`DIGIT_W*DIGITS-1:0] bcd_in,
  output logic digits_ok_out,
  output logic [`DIGIT_W*DIGITS-1:0] bin_out,
  input wire logic [`DIGIT_W*DIGITS-1:0] bin_in,
  output logic [`DIGIT_W*DIGITS-1:0] bcd_out
);
  localparam int W = `DIGIT_W * DIGITS;

  // True when every nibble is 0 to 9
  function automatic logic all_digits(input logic [W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (v[4*i +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : all_digits

  // Horner sum, times ten done as two shifts
  function automatic logic [W-1:0] to_bin(input logic [W-1:0] v);
    logic [W-1:0] acc;
    acc = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      acc = (acc << 3) + (acc << 1) + W'(v[4*i +: 4]);
    end
    return acc;
  endfunction : to_bin

  // Shift-and-add-three conversion
  function automatic logic [W-1:0] to_bcd(input logic [W-1:0] v);
    logic [W-1:0] b;
    b = '0;
    for (int i = W - 1; i >= 0; i--) begin
      for (int k = 0; k < DIGITS; k++) begin
        if (b[4*k +: 4] >= 4'h5) begin
          b[4*k +: 4] = b[4*k +: 4] + 4'h3;
        end
      end
      b = {b[W-2:0], v[i]};
    end
    return b;
  endfunction : to_bcd

  assign digits_ok_out = all_digits(bcd_in);
  assign bin_out = to_bin(bcd_in);
  assign bcd_out = to_bcd(bin_in);

endmodule : bcd_codec

`default_nettype wire

// ==== rtl/signed_and_bcd_divider.sv ====
// Division datapath: signed binary and BCD divide, single and double.
// Assumes request logic on the same clock; operands held while taken.
`timescale 1ns/1ps
`default_nettype none
`include "div_consts.svh"

module signed_and_bcd_divider
  import div_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire logic pulse_mode_in,
  input wire logic [`CODE_W-1:0] func_code_in,
  input wire logic [`WORD_W-1:0] dividend_first_word_in,
  input wire logic [`WORD_W-1:0] dividend_second_word_in,
  input wire logic [`WORD_W-1:0] divisor_first_word_in,
  input wire logic [`WORD_W-1:0] divisor_second_word_in,
  output logic req_ready_out,
  output logic done_out,
  output logic result_write_out,
  output logic result_double_out,
  output logic [`WORD_W-1:0] result_word0_out,
  output logic [`WORD_W-1:0] result_word1_out,
  output logic [`WORD_W-1:0] result_word2_out,
  output logic [`WORD_W-1:0] result_word3_out,
  output logic error_flag_out,
  output logic equals_flag_out,
  output logic negative_flag_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  div_state_type state_q, state_d;      // Sequencer
  div_op_type op_q, op_d;               // Operation in progress
  logic [`DWORD_W-1:0] dd_q, dd_d;      // Dividend, assembled
  logic [`DWORD_W-1:0] dr_q, dr_d;      // Divisor, assembled
  logic req_prev_q, req_prev_d;         // Request one cycle ago
  logic qneg_q, qneg_d;                 // Quotient to be negated
  logic rneg_q, rneg_d;                 // Remainder to be negated
  logic [3:0][`WORD_W-1:0] res_q, res_d; // Result words
  logic err_q, err_d;                   // Error flag
  logic eq_q, eq_d;                     // Equals flag
  logic neg_q, neg_d;                   // Negative flag
  logic wr_q, wr_d;                     // Result write pulse
  logic dbl_q, dbl_d;                   // Four words written
  logic take;                           // Request accepted
  logic is_bcd;                         // BCD operation
  logic is_dbl;                         // Double-word operation
  logic bad;                            // Operation refused
  logic dd_ok, dr_ok;                   // Operands are valid BCD
  logic [`DWORD_W-1:0] dd_bin, dr_bin;  // BCD operands as binary
  logic [`DWORD_W-1:0] q_bcd, r_bcd;    // Engine results as BCD
  logic [`DWORD_W-1:0] q_fin, r_fin;    // Final quotient, remainder

  div_if #(.WIDTH(`DWORD_W)) div_bus();

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Magnitude of a two's complement word
  function automatic logic [`DWORD_W-1:0] magnitude(
    input logic [`DWORD_W-1:0] v
  );
    return v[`SIGN_DOUBLE] ? `DWORD_W'(-v) : v;
  endfunction : magnitude

  // Conditional negation of an engine result
  function automatic logic [`DWORD_W-1:0] apply_sign(
    input logic [`DWORD_W-1:0] v,
    input logic flip
  );
    return flip ? `DWORD_W'(-v) : v;
  endfunction : apply_sign

  // Function code to operation
  function automatic div_op_type decode(input logic [`CODE_W-1:0] c);
    div_op_type op;
    op = OP_NONE;
    if (c == `FC_SIGNED_SINGLE) op = OP_SIGNED_SINGLE;
    if (c == `FC_SIGNED_DOUBLE) op = OP_SIGNED_DOUBLE;
    if (c == `FC_BCD_SINGLE) op = OP_BCD_SINGLE;
    if (c == `FC_BCD_DOUBLE) op = OP_BCD_DOUBLE_DIVIDE;
    return op;
  endfunction : decode

  // ****************************************************************
  // Engines
  // ****************************************************************
  mag_divider #(.WIDTH(`DWORD_W)) u_div (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .div_bus(div_bus)
  );

  // Dividend checks, and quotient back to BCD
  bcd_codec #(.DIGITS(8)) u_codec_dd (
    .bcd_in(dd_q),
    .digits_ok_out(dd_ok),
    .bin_out(dd_bin),
    .bin_in(div_bus.quotient),
    .bcd_out(q_bcd)
  );

  // Divisor checks, and remainder back to BCD
  bcd_codec #(.DIGITS(8)) u_codec_dr (
    .bcd_in(dr_q),
    .digits_ok_out(dr_ok),
    .bin_out(dr_bin),
    .bin_in(div_bus.remainder),
    .bcd_out(r_bcd)
  );

  // ****************************************************************
  // Operand decode
  // ****************************************************************
  // Classify the held operation and pick engine operands
  always_comb begin
    is_bcd = (op_q == OP_BCD_SINGLE) || (op_q == OP_BCD_DOUBLE_DIVIDE);
    is_dbl = (op_q == OP_SIGNED_DOUBLE) || (op_q == OP_BCD_DOUBLE_DIVIDE);
    // Unknown code, zero divisor, or bad digit
    bad = (op_q == OP_NONE) || (dr_q == '0)
      || (is_bcd && !(dd_ok && dr_ok));
    div_bus.dividend = is_bcd ? dd_bin : magnitude(dd_q);
    div_bus.divisor = is_bcd ? dr_bin : magnitude(dr_q);
    div_bus.start = (state_q == ST_PREP) && !bad;
    // Truncating division: remainder takes dividend sign
    q_fin = is_bcd ? q_bcd : apply_sign(div_bus.quotient, qneg_q);
    r_fin = is_bcd ? r_bcd : apply_sign(div_bus.remainder, rneg_q);
  end

  assign take = req_valid_in && (state_q == ST_IDLE)
    && (!pulse_mode_in || !req_prev_q);

  // ****************************************************************
  // Sequencer and result registers
  // ****************************************************************
  // Take, check, divide, then write back results and flags
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    dd_d = dd_q;
    dr_d = dr_q;
    req_prev_d = req_valid_in;
    qneg_d = qneg_q;
    rneg_d = rneg_q;
    res_d = res_q;
    err_d = err_q;
    eq_d = eq_q;
    neg_d = neg_q;
    wr_d = 1'b0;
    dbl_d = dbl_q;
    unique case (state_q)
      ST_IDLE: begin
        // Latch code and operands; low word is less significant
        if (take) begin
          op_d = decode(func_code_in);
          if (decode(func_code_in) == OP_SIGNED_DOUBLE
              || decode(func_code_in) == OP_BCD_DOUBLE_DIVIDE) begin
            dd_d = {dividend_second_word_in, dividend_first_word_in};
            dr_d = {divisor_second_word_in, divisor_first_word_in};
          end else if (decode(func_code_in) == OP_BCD_SINGLE) begin
            dd_d = {`WORD_RST, dividend_first_word_in};
            dr_d = {`WORD_RST, divisor_first_word_in};
          end else begin
            // Sign-extend single words into the wide engine
            dd_d = {{`WORD_W{dividend_first_word_in[`SIGN_SINGLE]}},
                    dividend_first_word_in};
            dr_d = {{`WORD_W{divisor_first_word_in[`SIGN_SINGLE]}},
                    divisor_first_word_in};
          end
          state_d = ST_PREP;
        end
      end
      ST_PREP: begin
        if (bad) begin
          // Flag the error; results and other flags stay put
          err_d = 1'b1;
          state_d = ST_DONE;
        end else begin
          qneg_d = !is_bcd && (dd_q[`SIGN_DOUBLE] ^ dr_q[`SIGN_DOUBLE]);
          rneg_d = !is_bcd && dd_q[`SIGN_DOUBLE];
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Overflow cases simply keep the wrapped value
        if (div_bus.done) begin
          err_d = 1'b0;
          wr_d = 1'b1;
          dbl_d = is_dbl;
          if (is_dbl) begin
            res_d[0] = q_fin[`WORD_W-1:0];
            res_d[1] = q_fin[`DWORD_W-1:`WORD_W];
            res_d[2] = r_fin[`WORD_W-1:0];
            res_d[3] = r_fin[`DWORD_W-1:`WORD_W];
            eq_d = (q_fin == '0);
          end else begin
            res_d[0] = q_fin[`WORD_W-1:0];
            res_d[1] = r_fin[`WORD_W-1:0];
            res_d[2] = `WORD_RST;
            res_d[3] = `WORD_RST;
            eq_d = (q_fin[`WORD_W-1:0] == '0);
          end
          // Sign flag only for binary operations
          if (!is_bcd) begin
            neg_d = is_dbl ? q_fin[`SIGN_DOUBLE]
                           : q_fin[`SIGN_SINGLE];
          end
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Register sequencer and results
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      dd_q <= '0;
      dr_q <= '0;
      req_prev_q <= 1'b0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      res_q <= '0;
      err_q <= `FLAG_RST;
      eq_q <= `FLAG_RST;
      neg_q <= `FLAG_RST;
      wr_q <= 1'b0;
      dbl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      dd_q <= dd_d;
      dr_q <= dr_d;
      req_prev_q <= req_prev_d;
      qneg_q <= qneg_d;
      rneg_q <= rneg_d;
      res_q <= res_d;
      err_q <= err_d;
      eq_q <= eq_d;
      neg_q <= neg_d;
      wr_q <= wr_d;
      dbl_q <= dbl_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready_out = (state_q == ST_IDLE);
  assign done_out = (state_q == ST_DONE);
  assign result_write_out = wr_q;
  assign result_double_out = dbl_q;
  assign result_word0_out = res_q[0];
  assign result_word1_out = res_q[1];
  assign result_word2_out = res_q[2];
  assign result_word3_out = res_q[3];
  assign error_flag_out = err_q;
  assign equals_flag_out = eq_q;
  assign negative_flag_out = neg_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_decode_signed;
    take && func_code_in == `FC_SIGNED_DOUBLE |=> op_q == OP_SIGNED_DOUBLE;
  endproperty
  a_decode_signed: assert property (p_decode_signed)
    else $error("code 431 not decoded as double signed");

  property p_decode_bcd;
    take && func_code_in == `FC_BCD_SINGLE |=> op_q == OP_BCD_SINGLE;
  endproperty
  a_decode_bcd: assert property (p_decode_bcd)
    else $error("code 434 not decoded as single bcd");

  property p_word_order;
    take && func_code_in == `FC_BCD_DOUBLE |=> dd_q ==
      {$past(dividend_second_word_in), $past(dividend_first_word_in)};
  endproperty
  a_word_order: assert property (p_word_order)
    else $error("double dividend halves swapped");

  property p_zero_divisor;
    state_q == ST_PREP && !is_bcd && dr_q == '0
      |=> done_out && error_flag_out && !result_write_out;
  endproperty
  a_zero_divisor: assert property (p_zero_divisor)
    else $error("zero divisor did not raise error");

  property p_bcd_digit;
    state_q == ST_PREP && is_bcd && !dd_ok |=> error_flag_out ##1 !done_out;
  endproperty
  a_bcd_digit: assert property (p_bcd_digit)
    else $error("bad bcd digit did not raise error");

  property p_hold_on_error;
    state_q == ST_PREP && bad |=> $stable(res_q) && $stable(eq_q);
  endproperty
  a_hold_on_error: assert property (p_hold_on_error)
    else $error("results changed on error");

  property p_equals;
    result_write_out |-> equals_flag_out == (result_double_out
      ? {result_word1_out, result_word0_out} == '0
      : result_word0_out == '0);
  endproperty
  a_equals: assert property (p_equals)
    else $error("equals flag disagrees with quotient");

  property p_negative;
    result_write_out && !is_bcd |-> negative_flag_out ==
      (result_double_out ? result_word1_out[`SIGN_SINGLE]
                         : result_word0_out[`SIGN_SINGLE]);
  endproperty
  a_negative: assert property (p_negative)
    else $error("negative flag disagrees with quotient");

  property p_single_math;
    result_write_out && op_q == OP_SIGNED_SINGLE
      && !(dd_q[`WORD_W-1:0] == 16'h8000 && dr_q[`WORD_W-1:0] == 16'hffff)
      |-> `WORD_W'($signed(result_word0_out) * $signed(dr_q[`WORD_W-1:0])
        + $signed(result_word1_out)) == dd_q[`WORD_W-1:0];
  endproperty
  a_single_math: assert property (p_single_math)
    else $error("single signed result inconsistent");

  property p_double_math;
    result_write_out && op_q == OP_SIGNED_DOUBLE
      && !(dd_q == 32'h80000000 && dr_q == 32'hffffffff)
      |-> `DWORD_W'($signed({result_word1_out, result_word0_out})
        * $signed(dr_q) + $signed({result_word3_out, result_word2_out}))
        == dd_q;
  endproperty
  a_double_math: assert property (p_double_math)
    else $error("double signed result inconsistent");

endmodule : signed_and_bcd_divider

`default_nettype wire

// ==== tb/div_requester.sv ====
// Requester model: the controller side that issues division requests.
// Assumes one clock shared with the divider and its ready output.
`timescale 1ns/1ps
`default_nettype none
`include "div_consts.svh"

module div_requester (
  input wire logic ref_clk_in,
  input wire logic req_ready_in,
  output logic req_valid_out,
  output logic pulse_mode_out,
  output logic [`CODE_W-1:0] func_code_out,
  output logic [`DWORD_W-1:0] dividend_out,
  output logic [`DWORD_W-1:0] divisor_out
);
  // Idle values from time zero
  initial begin
    req_valid_out = 1'b0;
    pulse_mode_out = 1'b0;
    func_code_out = '0;
    dividend_out = '0;
    divisor_out = '0;
  end

  // Hold one request with its operands until the edge that takes it
  task automatic issue(input logic [`CODE_W-1:0] c,
                       input logic [`DWORD_W-1:0] a, b, input logic p);
    @(posedge ref_clk_in);
    req_valid_out <= 1'b1;
    pulse_mode_out <= p;
    func_code_out <= c;
    dividend_out <= a;
    divisor_out <= b;
    do @(posedge ref_clk_in); while (req_ready_in !== 1'b1);
    req_valid_out <= 1'b0;
    // Released operands show garbage, not their last value
    dividend_out <= ~a;
    divisor_out <= ~b;
  endtask : issue

  // Keep one request standing for a number of edges, then drop it
  task automatic hold(input logic [`CODE_W-1:0] c,
                      input logic [`DWORD_W-1:0] a, b, input logic p,
                      input int n);
    @(posedge ref_clk_in);
    req_valid_out <= 1'b1;
    pulse_mode_out <= p;
    func_code_out <= c;
    dividend_out <= a;
    divisor_out <= b;
    repeat (n) @(posedge ref_clk_in);
    req_valid_out <= 1'b0;
  endtask : hold
endmodule : div_requester
`default_nettype wire

// ==== tb/signed_and_bcd_divider_tb.sv ====
// Self-checking bench for the signed and BCD division datapath.
// Assumes the requester model and the design's constants header.
`timescale 1ns/1ps
`default_nettype none
`include "div_consts.svh"

module signed_and_bcd_divider_tb;
  localparam int LAT_OK = 34; // Edges after take edge to done, good op
  localparam int LAT_ERR = 1; // Edges after take edge to done, error
  logic clk, rst_n, valid, pulse, ready, done, wr, dbl, err, eq, neg;
  logic [9:0] code;
  logic [31:0] dd, dr;
  logic [15:0] w0, w1, w2, w3;
  logic [63:0] ew; // Expected result words, word 3 on top
  logic ee, eeq, en, ed; // Expected error, equals, negative, double
  int mismatches = 0;
  int total_checks = 0;

  div_requester req (.ref_clk_in(clk), .req_ready_in(ready),
    .req_valid_out(valid), .pulse_mode_out(pulse), .func_code_out(code),
    .dividend_out(dd), .divisor_out(dr));
  signed_and_bcd_divider uut (.ref_clk_in(clk), .arst_n_in(rst_n),
    .req_valid_in(valid), .pulse_mode_in(pulse), .func_code_in(code),
    .dividend_first_word_in(dd[15:0]), .dividend_second_word_in(dd[31:16]),
    .divisor_first_word_in(dr[15:0]), .divisor_second_word_in(dr[31:16]),
    .req_ready_out(ready), .done_out(done), .result_write_out(wr),
    .result_double_out(dbl), .result_word0_out(w0), .result_word1_out(w1),
    .result_word2_out(w2), .result_word3_out(w3), .error_flag_out(err),
    .equals_flag_out(eq), .negative_flag_out(neg));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] from_bcd(input logic [31:0] v);
    from_bcd = 0;
    for (int i = 7; i >= 0; i--) from_bcd = from_bcd * 10 + v[i*4+:4];
  endfunction : from_bcd

  function automatic logic [31:0] to_bcd(input logic [31:0] v);
    for (int i = 0; i < 8; i++) begin
      to_bcd[i*4+:4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction : to_bcd

  function automatic logic is_bcd(input logic [31:0] v);
    is_bcd = 1'b1;
    for (int i = 0; i < 8; i++) if (v[i*4+:4] > 4'h9) is_bcd = 1'b0;
  endfunction : is_bcd

  function automatic logic [31:0] rand_bcd();
    for (int i = 0; i < 8; i++) rand_bcd[i*4+:4] = 4'($urandom_range(0, 9));
    rand_bcd = rand_bcd >> (4 * $urandom_range(0, 7));
  endfunction : rand_bcd

  // Work out the expected outcome; error leaves old results standing
  task automatic predict(input logic [9:0] c, input logic [31:0] a, b);
    logic signed [31:0] sa, sb;
    logic [31:0] q, r;
    logic d, bad, nq;
    d = c[0];
    nq = en;
    if (c == `FC_SIGNED_SINGLE || c == `FC_SIGNED_DOUBLE) begin
      sa = d ? a : {{16{a[15]}}, a[15:0]};
      sb = d ? b : {{16{b[15]}}, b[15:0]};
      bad = (sb == 0);
      q = bad ? 0 : sa / sb;
      r = bad ? 0 : sa % sb;
      nq = d ? q[31] : q[15];
    end else if (c == `FC_BCD_SINGLE || c == `FC_BCD_DOUBLE) begin
      sa = d ? a : {16'h0, a[15:0]};
      sb = d ? b : {16'h0, b[15:0]};
      bad = !is_bcd(sa) || !is_bcd(sb) || sb == 0;
      q = bad ? 0 : to_bcd(from_bcd(sa) / from_bcd(sb));
      r = bad ? 0 : to_bcd(from_bcd(sa) % from_bcd(sb));
    end else bad = 1'b1;
    ee = bad;
    if (!bad) begin
      ed = d;
      en = nq;
      eeq = d ? (q == 0) : (q[15:0] == 0);
      ew = d ? {r, q} : {32'h0, r[15:0], q[15:0]};
    end
  endtask : predict

  // One operation: request, timing of the answer, then results
  task automatic run(input logic [9:0] c, input logic [31:0] a, b);
    int n;
    predict(c, a, b);
    req.issue(c, a, b, 1'($urandom_range(0, 1)));
    #1;
    check(ready, 1'b0);
    for (n = 1; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    check(n, ee ? LAT_ERR : LAT_OK);
    check(wr, !ee);
    check({w3, w2, w1, w0}, ew);
    check({err, eq, neg, dbl}, {ee, eeq, en, ed});
    @(posedge clk);
    #1;
    check(ready, 1'b1);
  endtask : run

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (10000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    logic [9:0] codes [4];
    logic [9:0] c;
    logic [31:0] a, b;
    int k;
    codes = '{`FC_SIGNED_SINGLE, `FC_SIGNED_DOUBLE, `FC_BCD_SINGLE,
              `FC_BCD_DOUBLE};
    {ew, ee, eeq, en, ed} = '0;
    rst_n = 1'b0;
    void'($urandom(69));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({ready, done, wr, err, eq, neg, dbl}, 7'b1000000);
    // Corner cases first
    run(`FC_SIGNED_SINGLE, 32'h0000_fff9, 32'h0000_0002);
    run(`FC_SIGNED_SINGLE, 32'h0000_0007, 32'h0001_0000);
    run(`FC_SIGNED_SINGLE, 32'h0000_0005, 32'h0000_0007);
    run(`FC_SIGNED_DOUBLE, 32'h8000_0000, 32'h0000_0003);
    run(`FC_SIGNED_DOUBLE, 32'h0000_0064, 32'h0000_0000);
    run(`FC_BCD_SINGLE, 32'h0000_12a4, 32'h0000_0003);
    run(`FC_BCD_SINGLE, 32'h0000_0099, 32'h0000_0000);
    run(`FC_BCD_DOUBLE, 32'h9999_9999, 32'h0000_0003);
    run(`FC_BCD_DOUBLE, 32'h0000_0005, 32'h0001_0000);
    run(`FC_BCD_DOUBLE, 32'h0000_0005, 32'h00b0_0001);
    run(10'h1b0, 32'h0000_0001, 32'h0000_0001);
    // Held request: level mode retakes each time idle, pulse mode once
    for (int p = 0; p < 2; p++) begin
      k = 0;
      fork
        req.hold(`FC_SIGNED_SINGLE, 32'h0000_0005, 32'h0000_0000, 1'(p), 9);
        repeat (12) begin
          @(posedge clk);
          #1;
          if (done === 1'b1) k++;
        end
      join
      check(k, (p == 1) ? 1 : 3);
      check(err, 1'b1);
    end
    // Random traffic over all four operations
    repeat (60) begin
      c = codes[$urandom_range(0, 3)];
      if (c >= `FC_BCD_SINGLE) begin
        a = rand_bcd();
        b = rand_bcd();
      end else begin
        a = $urandom;
        b = $urandom >> $urandom_range(0, 31);
        if (b[15:0] == 16'hffff) b[0] = 1'b0;
      end
      run(c, a, b);
    end
    test_done();
  end
endmodule : signed_and_bcd_divider_tb
`default_nettype wire
